// >>> rtl/gpio_expander.sv
// Sixteen-bit I/O expander: two-wire target, APB register view, interrupt logic
//
// Contract
// - Two 8-bit ports, each with direction, input, output and polarity registers.
// - Each line is input or output per its own master-written direction bit.
// - Input register holds sampled inputs; output pins driven from output register.
// - Set polarity bit inverts that line's input value as read back.
// - Every register, direction, output and polarity included, is readable.
// - Open-drain low interrupt while any input differs from latched input register.
// - Power-up loads all registers with defaults and initialises bus machine.
// - Reset input is active low; needs external pull-up when undriven.
// - Full-reset variant: low reset holds registers and bus machine at defaults.
// - Bus-only variant: low reset restarts bus machine, keeps registers and lines.
// - Two address-select pins alter the fixed target address; four devices share.
// - After reset all sixteen lines are inputs.
// - Bus works at any clock rate up to the maximum; master stays below it.
// - Serial clock and data inputs are noise filtered before the bus machine.
// - Lines do not glitch at power-up; stay inputs until configured.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module gpio_expander (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic bus_reset_n,
  input wire logic [15:0] gpio_i,
  output logic [15:0] gpio_o,
  output logic [15:0] gpio_oe,
  output logic change_int_n_o,
  output logic change_int_n_oe,
  output logic irq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Replace one byte of a port pair
  function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = v;
    if (hi) begin
      r[15:8] = b;
    end else begin
      r[7:0] = b;
    end
    return r;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction : get_byte

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [20:0] sync1_r, sync2_r, sync3_r, held_r;
  logic [1:0] filt_r;
  logic [2:0] filt_cnt_r [2];
  logic scl_d_r, sda_d_r;
  logic scl_f, sda_f, scl_rise, scl_fall, start_cond, stop_cond;
  logic bus_rst, reg_rst;
  gpio_expander_pkg::tgt_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic is_addr_r, got_cmd_r, rw_r, nack_r;
  logic [2:0] cmd_r;
  logic [6:0] my_addr;
  logic i2c_wr, i2c_rd_in;
  logic [15:0] out_r, pol_r, dir_r, in_r;
  logic [15:0] in_view, pins;
  logic change, change_d_r;
  logic [2:0] irq_sts_r, irq_mask_r, irq_ev;
  logic bus_only_r;
  logic apb_setup, apb_wr, apb_rd, apb_hit;
  logic [31:0] rd_val;
  logic rd_hi;

  assign pins = held_r[15:0];
  assign scl_f = filt_r[1];
  assign sda_f = filt_r[0];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Three stages; a change is accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= gpio_expander_pkg::SYNC_RST;
      sync2_r <= gpio_expander_pkg::SYNC_RST;
      sync3_r <= gpio_expander_pkg::SYNC_RST;
    end else begin
      sync1_r <= {bus_reset_n, addr_select_bit1, addr_select_bit0, scl_i, sda_i, gpio_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= gpio_expander_pkg::SYNC_RST;
    end else begin
      held_r <= (sync2_r & sync3_r) | (held_r & (sync2_r ^ sync3_r));
    end
  end

  // Spike filter: a level must hold a few cycles before the bus machine sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= 2'h3;
      filt_cnt_r[0] <= 3'h0;
      filt_cnt_r[1] <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (held_r[gpio_expander_pkg::SY_SDA + i] == filt_r[i]) begin
          filt_cnt_r[i] <= 3'h0;
        end else if (filt_cnt_r[i] == 3'(gpio_expander_pkg::FILT_CYC - 1)) begin
          filt_r[i] <= held_r[gpio_expander_pkg::SY_SDA + i];
          filt_cnt_r[i] <= 3'h0;
        end else begin
          filt_cnt_r[i] <= filt_cnt_r[i] + 3'h1;
        end
      end
    end
  end

  // Edge and condition detection on the filtered lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_cond = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_cond = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ----------------------------------------
  // Reset pin handling
  // ----------------------------------------
  // Pin is active low; bus machine always restarts, registers only in full variant
  assign bus_rst = ~held_r[gpio_expander_pkg::SY_RST];
  assign reg_rst = bus_rst & ~bus_only_r;

  // Address pins fill the two low bits of the fixed address
  assign my_addr = {gpio_expander_pkg::BUS_ADDR_HI, held_r[gpio_expander_pkg::SY_A1],
                    held_r[gpio_expander_pkg::SY_A0]};

  // ----------------------------------------
  // Serial target state machine
  // ----------------------------------------
  // Works only from observed edges, so any clock rate up to the limit is fine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= gpio_expander_pkg::ST_IDLE;
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      is_addr_r <= 1'b0;
      got_cmd_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      cmd_r <= 3'h0;
    end else if (bus_rst) begin
      state_r <= gpio_expander_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      got_cmd_r <= 1'b0;
    end else if (start_cond) begin
      state_r <= gpio_expander_pkg::ST_RX;
      bitcnt_r <= 4'h0;
      is_addr_r <= 1'b1;
      got_cmd_r <= 1'b0;
    end else if (stop_cond) begin
      state_r <= gpio_expander_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        gpio_expander_pkg::ST_IDLE: begin
          bitcnt_r <= 4'h0;
        end
        gpio_expander_pkg::ST_RX: begin
          if (scl_rise && bitcnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_f};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (is_addr_r) begin
              if (shift_r[7:1] == my_addr) begin
                rw_r <= shift_r[0];
                state_r <= gpio_expander_pkg::ST_ACK;
              end else begin
                state_r <= gpio_expander_pkg::ST_IDLE; // Not for us
              end
            end else if (!got_cmd_r) begin
              cmd_r <= shift_r[2:0];
              got_cmd_r <= 1'b1;
              state_r <= gpio_expander_pkg::ST_ACK;
            end else begin
              cmd_r <= {cmd_r[2:1], ~cmd_r[0]}; // Steps within the port pair
              state_r <= gpio_expander_pkg::ST_ACK;
            end
          end
        end
        gpio_expander_pkg::ST_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            is_addr_r <= 1'b0;
            if (rw_r && is_addr_r) begin
              shift_r <= rd_val[7:0];
              state_r <= gpio_expander_pkg::ST_TX;
            end else begin
              state_r <= gpio_expander_pkg::ST_RX;
            end
          end
        end
        gpio_expander_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == 4'h7) begin
              state_r <= gpio_expander_pkg::ST_RACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        gpio_expander_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_f;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_r <= gpio_expander_pkg::ST_IDLE;
            end else begin
              cmd_r <= {cmd_r[2:1], ~cmd_r[0]};
              shift_r <= rd_val[7:0];
              bitcnt_r <= 4'h0;
              state_r <= gpio_expander_pkg::ST_TX;
            end
          end
        end
      endcase
    end
  end

  // Byte strobes from the serial side; read data is the commanded port's byte, then the other port's after each ack
  assign i2c_wr = (state_r == gpio_expander_pkg::ST_RX) && scl_fall && bitcnt_r == 4'h8 &&
                  !is_addr_r && got_cmd_r && !bus_rst && !start_cond && !stop_cond;
  assign i2c_rd_in = ((state_r == gpio_expander_pkg::ST_ACK && rw_r && is_addr_r) ||
                      (state_r == gpio_expander_pkg::ST_RACK && !nack_r)) && scl_fall &&
                     cmd_r[2:1] == gpio_expander_pkg::CMD_INPUT && !bus_rst;

  // Open drain: pull low for ack and for zero data bits
  always_comb begin
    sda_o = 1'b0;
    sda_oe = 1'b0;
    if (state_r == gpio_expander_pkg::ST_ACK) begin
      sda_oe = 1'b1;
    end else if (state_r == gpio_expander_pkg::ST_TX) begin
      sda_oe = ~shift_r[7];
    end
  end

  // ----------------------------------------
  // General purpose registers
  // ----------------------------------------
  // APB write lands after the serial one, so it wins a same-cycle clash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= gpio_expander_pkg::DIRECTION_RST;
    end else if (reg_rst) begin
      dir_r <= gpio_expander_pkg::DIRECTION_RST;
    end else begin
      if (i2c_wr && cmd_r[2:1] == gpio_expander_pkg::CMD_DIRECTION) begin
        dir_r <= put_byte(dir_r, cmd_r[0], shift_r);
      end
      if (apb_wr && paddr == gpio_expander_pkg::OFF_DIRECTION) begin
        dir_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= gpio_expander_pkg::OUTPUT_RST;
    end else if (reg_rst) begin
      out_r <= gpio_expander_pkg::OUTPUT_RST;
    end else begin
      if (i2c_wr && cmd_r[2:1] == gpio_expander_pkg::CMD_OUTPUT) begin
        out_r <= put_byte(out_r, cmd_r[0], shift_r);
      end
      if (apb_wr && paddr == gpio_expander_pkg::OFF_OUTPUT) begin
        out_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= gpio_expander_pkg::POLARITY_RST;
    end else if (reg_rst) begin
      pol_r <= gpio_expander_pkg::POLARITY_RST;
    end else begin
      if (i2c_wr && cmd_r[2:1] == gpio_expander_pkg::CMD_POLARITY) begin
        pol_r <= put_byte(pol_r, cmd_r[0], shift_r);
      end
      if (apb_wr && paddr == gpio_expander_pkg::OFF_POLARITY) begin
        pol_r <= pwdata[15:0];
      end
    end
  end

  // Input register latches the pins whenever it is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_r <= 16'h0000;
    end else if (reg_rst) begin
      in_r <= pins;
    end else if (i2c_rd_in || (apb_rd && paddr == gpio_expander_pkg::OFF_INPUT)) begin
      in_r <= pins;
    end
  end

  assign in_view = in_r ^ pol_r;

  // Direction bit one means input; no drive until configured
  assign gpio_oe = ~dir_r;
  assign gpio_o = out_r;

  // ----------------------------------------
  // Read value for the serial register view
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h00000000;
    rd_hi = cmd_r[0] ^ (state_r == gpio_expander_pkg::ST_RACK); // Next port after an ack
    if (state_r == gpio_expander_pkg::ST_ACK || state_r == gpio_expander_pkg::ST_RACK) begin
      unique case (cmd_r[2:1])
        gpio_expander_pkg::CMD_INPUT: rd_val[7:0] = get_byte(pins ^ pol_r, rd_hi);
        gpio_expander_pkg::CMD_OUTPUT: rd_val[7:0] = get_byte(out_r, rd_hi);
        gpio_expander_pkg::CMD_POLARITY: rd_val[7:0] = get_byte(pol_r, rd_hi);
        gpio_expander_pkg::CMD_DIRECTION: rd_val[7:0] = get_byte(dir_r, rd_hi);
      endcase
    end
  end

  // ----------------------------------------
  // Change detect and interrupts
  // ----------------------------------------
  // Only lines set as inputs can raise the change flag
  assign change = |((pins ^ in_r) & dir_r);
  assign change_int_n_o = 1'b0;
  assign change_int_n_oe = change;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_d_r <= 1'b0;
    end else begin
      change_d_r <= change;
    end
  end

  always_comb begin
    irq_ev = 3'h0;
    irq_ev[gpio_expander_pkg::IRQ_CHANGE] = change & ~change_d_r;
    irq_ev[gpio_expander_pkg::IRQ_WRITE] = i2c_wr;
    irq_ev[gpio_expander_pkg::IRQ_BUSRST] = bus_rst;
  end

  // Sticky status: a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= 3'h0;
    end else if (apb_wr && paddr == gpio_expander_pkg::OFF_IRQ_STATUS) begin
      irq_sts_r <= (irq_sts_r & ~pwdata[2:0]) | irq_ev;
    end else begin
      irq_sts_r <= irq_sts_r | irq_ev;
    end
  end

  // Mask and variant select survive the reset pin; only power-on clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= gpio_expander_pkg::IRQ_MASK_RST;
      bus_only_r <= gpio_expander_pkg::CTRL_BUS_ONLY_RST;
    end else if (apb_wr) begin
      if (paddr == gpio_expander_pkg::OFF_IRQ_MASK) begin
        irq_mask_r <= pwdata[2:0];
      end
      if (paddr == gpio_expander_pkg::OFF_CTRL) begin
        bus_only_r <= pwdata[gpio_expander_pkg::CTRL_BUS_ONLY];
      end
    end
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states: read data is captured in the setup cycle
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & apb_hit;
  assign apb_rd = psel & penable & ~pwrite & apb_hit;
  assign apb_hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= 32'h00000000;
      unique case (paddr)
        gpio_expander_pkg::OFF_INPUT: prdata[15:0] <= pins ^ pol_r;
        gpio_expander_pkg::OFF_OUTPUT: prdata[15:0] <= out_r;
        gpio_expander_pkg::OFF_POLARITY: prdata[15:0] <= pol_r;
        gpio_expander_pkg::OFF_DIRECTION: prdata[15:0] <= dir_r;
        gpio_expander_pkg::OFF_IRQ_STATUS: prdata[2:0] <= irq_sts_r;
        gpio_expander_pkg::OFF_IRQ_MASK: prdata[2:0] <= irq_mask_r;
        gpio_expander_pkg::OFF_CTRL: prdata[gpio_expander_pkg::CTRL_BUS_ONLY] <= bus_only_r;
        gpio_expander_pkg::OFF_STATUS: begin
          prdata[gpio_expander_pkg::STAT_BUSY] <= state_r != gpio_expander_pkg::ST_IDLE;
          prdata[gpio_expander_pkg::STAT_CHANGE] <= change;
          prdata[gpio_expander_pkg::STAT_ASEL +: 2] <= my_addr[1:0];
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : gpio_expander

// >>> rtl/gpio_expander_pkg.sv
// Constants, register map and state codes for the two-wire sixteen-bit I/O expander
package gpio_expander_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS = 50;
  // Least time, rounded up to whole cycles
  localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // APB register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_INPUT = 8'h00;
  localparam logic [7:0] OFF_OUTPUT = 8'h04;
  localparam logic [7:0] OFF_POLARITY = 8'h08;
  localparam logic [7:0] OFF_DIRECTION = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] OUTPUT_RST = 16'hFFFF;
  localparam logic [15:0] POLARITY_RST = 16'h0000;
  localparam logic [15:0] DIRECTION_RST = 16'hFFFF;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic CTRL_BUS_ONLY_RST = 1'b0;
  // Arbitrary upper bits of the target address, not tied to any product
  localparam logic [4:0] BUS_ADDR_HI = 5'h0A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IRQ_CHANGE = 0;
  localparam int IRQ_WRITE = 1;
  localparam int IRQ_BUSRST = 2;
  localparam int CTRL_BUS_ONLY = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CHANGE = 1;
  localparam int STAT_ASEL = 16;

  // ----------------------------------------
  // Command byte: upper bits pick register, bit 0 picks port
  // ----------------------------------------
  localparam logic [1:0] CMD_INPUT = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_POLARITY = 2'h2;
  localparam logic [1:0] CMD_DIRECTION = 2'h3;

  // ----------------------------------------
  // Synchroniser bit positions and reset value
  // ----------------------------------------
  localparam int SYNC_W = 21;
  localparam int SY_SDA = 16;
  localparam int SY_SCL = 17;
  localparam int SY_A0 = 18;
  localparam int SY_A1 = 19;
  localparam int SY_RST = 20;
  localparam logic [20:0] SYNC_RST = 21'h130000;

  // ----------------------------------------
  // Serial target states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_RACK = 5'b10000
  } tgt_state_t;

endpackage : gpio_expander_pkg

// >>> dv/host_model.sv
// Two-wire bus master model for the expander's serial side
`timescale 1ns/1ns
module host_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ----------------------------------------
  // Bus timing and transfers
  // ----------------------------------------
  // Half period of 400 kHz, the top rate the target must handle
  localparam int HALF_NS = 1250;
  // Both lines released while idle
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One clock pulse; data held 200 ns past the fall to clear the filter
  task automatic pulse(output logic v);
    #HALF_NS scl = 1'b1;
    #(HALF_NS / 2) v = sda;
    #(HALF_NS / 2) scl = 1'b0;
    #200;
  endtask : pulse
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_pull = 1'b1;
    #HALF_NS scl = 1'b0;
    #200;
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    sda_pull = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_pull = 1'b0;
    #HALF_NS;
  endtask : stop
  // Byte out, most significant bit first, then the target's answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !d[i];
      pulse(v);
    end
    sda_pull = 1'b0;
    pulse(v);
    ack = !v;
  endtask : wbyte
  // Byte in; ack set pulls the line low, otherwise a closing nack
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic v;
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    sda_pull = ack;
    pulse(v);
  endtask : rbyte
endmodule : host_model

// >>> dv/io_check_assertions.sv
// Port-level assertions for the sixteen-bit I/O expander
`timescale 1ns/1ns
module io_check (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [15:0] gpio_i,
  input wire logic [15:0] gpio_o,
  input wire logic [15:0] gpio_oe,
  input wire logic change_int_n_oe,
  input wire logic irq
);
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phases and the written low half
  wire wa = psel && penable && pwrite;
  wire ra = psel && penable && !pwrite;
  wire [15:0] wlo = pwdata[15:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  dir_drive_a:
    assert property (wa && paddr == 8'h0C |=> gpio_oe == ~$past(wlo))
    else $error("direction write not on enables");
  out_drive_a:
    assert property (wa && paddr == 8'h04 |=> gpio_o == $past(wlo))
    else $error("output write not on pins");
  dir_read_a:
    assert property (ra && paddr == 8'h0C |-> prdata[15:0] == ~gpio_oe)
    else $error("direction readback wrong");
  out_read_a:
    assert property (ra && paddr == 8'h04 |-> prdata[15:0] == gpio_o)
    else $error("output readback wrong");
  reset_dflt_a:
    assert property ($rose(presetn) |-> gpio_oe == 16'h0000 && gpio_o == 16'hFFFF)
    else $error("lines not inputs after reset");
  int_release_a:
    assert property ($stable(gpio_i) [*6] ##1 (ra && paddr == 8'h00) |=> !change_int_n_oe)
    else $error("interrupt held after input read");
  mask_off_a:
    assert property (wa && paddr == 8'h14 && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all masked");
  unmapped_a:
    assert property (psel && penable && paddr >= 8'h20 |-> pslverr)
    else $error("unmapped access not refused");
endmodule : io_check

bind gpio_expander io_check u_io_check (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .gpio_i, .gpio_o, .gpio_oe, .change_int_n_oe, .irq);

// >>> dv/tb.sv
// Self-checking bench for the sixteen-bit I/O expander
`timescale 1ns/1ns
module tb;
  // ----------------------------------------
  // Signals and bench model state
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl, m_pull, e;
  logic addr_select_bit0, addr_select_bit1, bus_reset_n, sda_oe, change_int_n_oe, irq;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] ext, gpio_o, gpio_oe, m_out, m_dir, m_pol;
  logic [6:0] ab;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Pulled-up data line and pins resolved from all drivers
  wire sda = !(sda_oe || m_pull);
  wire [15:0] pins = (gpio_oe & gpio_o) | (~gpio_oe & ext);
  gpio_expander dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe, .addr_select_bit0,
    .addr_select_bit1, .bus_reset_n, .gpio_i(pins), .gpio_o, .gpio_oe, .change_int_n_o(),
    .change_int_n_oe, .irq);
  host_model p (.scl, .sda_pull(m_pull), .sda);
  // Free-running system clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] y);
    samples_checked++;
    if (y !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  // Bus cycle; request held until pready, result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic sw(input logic [7:0] v, input logic x);
    logic a;
    p.wbyte(v, a);
    chk("ack", 16'(x), 16'(a));
  endtask : sw
  // Reset pin low long enough to clear its synchroniser
  task automatic brst();
    @(posedge pclk);
    bus_reset_n <= 1'b0;
    repeat (10) @(posedge pclk);
    bus_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : brst
  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(34572));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bus_reset_n = 1'b1;
    {addr_select_bit1, addr_select_bit0} = 2'($urandom);
    ext = 16'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("oe", 16'h0000, gpio_oe);
    for (int i = 1; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("dflt", (i == 2) ? 16'h0000 : 16'hFFFF, q[15:0]);
    end
    // Random settings, read back and seen at the pins
    for (int i = 0; i < 6; i++) begin
      {m_out, m_dir, m_pol} = {16'($urandom), 16'($urandom), 16'($urandom)};
      apb(1'b1, 8'h04, {16'h0000, m_out});
      apb(1'b1, 8'h0C, {16'h0000, m_dir});
      apb(1'b1, 8'h08, {16'h0000, m_pol});
      ext <= 16'($urandom);
      repeat (8) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      chk("pol", m_pol, q[15:0]);
      apb(1'b0, 8'h00, 32'h0);
      chk("input", ((m_out & ~m_dir) | (m_dir & ext)) ^ m_pol, q[15:0]);
      chk("pins", m_out, gpio_o);
      chk("oe", ~m_dir, gpio_oe);
    end
    // Change interrupt: raise, release by return, raise, release by read
    apb(1'b1, 8'h0C, 32'h0000FFFF);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq", 16'h0000, 16'(irq));
    m_pol = ext;
    for (int i = 0; i < 2; i++) begin
      ext <= m_pol ^ 16'h8001;
      repeat (8) @(posedge pclk);
      chk("int", 16'h0001, 16'(change_int_n_oe));
      chk("irq", 16'h0001, 16'(irq));
      if (i == 0) ext <= m_pol;
      else apb(1'b0, 8'h00, 32'h0);
      repeat (8) @(posedge pclk);
      chk("int", 16'h0000, 16'(change_int_n_oe));
    end
    apb(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 16'h0000, 16'(irq));
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h20, 32'h0);
    chk("slverr", 16'h0001, 16'(e));
    apb(1'b0, 8'h1C, 32'h0);
    chk("asel", {14'h0, addr_select_bit1, addr_select_bit0}, {14'h0, q[17:16]});
    // Serial write of both output bytes, port bit toggling
    ab = {gpio_expander_pkg::BUS_ADDR_HI, addr_select_bit1, addr_select_bit0};
    m_out = 16'($urandom);
    p.start();
    sw({ab, 1'b0}, 1'b1);
    sw({5'h00, gpio_expander_pkg::CMD_OUTPUT, 1'b0}, 1'b1);
    sw(m_out[7:0], 1'b1);
    sw(m_out[15:8], 1'b1);
    p.stop();
    apb(1'b0, 8'h04, 32'h0);
    chk("ser_out", m_out, q[15:0]);
    // Serial read of direction through a repeated start
    m_dir = 16'($urandom);
    apb(1'b1, 8'h0C, {16'h0000, m_dir});
    p.start();
    sw({ab, 1'b0}, 1'b1);
    sw({5'h00, gpio_expander_pkg::CMD_DIRECTION, 1'b0}, 1'b1);
    p.start();
    sw({ab, 1'b1}, 1'b1);
    p.rbyte(b, 1'b1);
    chk("ser_lo", {8'h00, m_dir[7:0]}, {8'h00, b});
    p.rbyte(b, 1'b0);
    chk("ser_hi", {8'h00, m_dir[15:8]}, {8'h00, b});
    p.stop();
    p.start();
    sw({ab ^ 7'h01, 1'b0}, 1'b0);
    p.stop();
    // Reset pin: bus-only variant keeps lines, full variant clears them
    apb(1'b1, 8'h18, 32'h1);
    brst();
    apb(1'b0, 8'h0C, 32'h0);
    chk("keep_dir", m_dir, q[15:0]);
    chk("keep_oe", ~m_dir, gpio_oe);
    apb(1'b1, 8'h18, 32'h0);
    brst();
    apb(1'b0, 8'h0C, 32'h0);
    chk("rst_dir", 16'hFFFF, q[15:0]);
    chk("rst_oe", 16'h0000, gpio_oe);
    finish_test();
  end
  // Hang guard, well past the expected serial traffic time
  initial begin
    #600000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb
